// [logic/motor_status_pkg.sv]
// Package with offsets, field layouts and reset values for the status bank
package motor_status_pkg;

	// Register word and address widths
	localparam int WORD_W = 16;
	localparam int ADDR_W = 8;
	localparam int BYTE_W = 8;
	localparam int ADC_W = 10;

	// Register word offsets; the serial interface addresses whole words
	localparam logic [7:0] OFS_POSITION_SUPPLY = 8'h05;
	localparam logic [7:0] OFS_SPEED_READBACK = 8'h06;
	localparam logic [7:0] OFS_ANALOG_LEVEL = 8'h07;
	localparam logic [7:0] OFS_IDENT = 8'h08;

	// Field positions inside each 16-bit word
	localparam int HI_BYTE_LSB = 8;
	localparam int LO_BYTE_LSB = 0;
	localparam int ADC_LSB = 0;
	localparam int ADC_RSVD_LSB = 10;
	localparam int ADC_RSVD_W = 6;

	// Reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_ADC = 10'h000;
	localparam logic [5:0] RSVD_ZERO = 6'h00;

	// Answer to an unmapped offset
	localparam logic [15:0] UNMAPPED_WORD = 16'h0000;

	// Identification defaults; both values are arbitrary
	localparam logic [7:0] DIE_ID_DEFAULT = 8'h5a;
	localparam logic [7:0] REV_ID_DEFAULT = 8'h03;

	// Scale figures of the reported codes, kept for reference by software
	localparam int SUPPLY_FULL_SCALE_V = 30;
	localparam int SUPPLY_CODE_SPAN = 255;
	localparam int ADC_CODE_SPAN = 1024;
	localparam logic [7:0] FULL_SPEED_CODE = 8'hff;

	// Read port state
	typedef enum logic [1:0] {
		RD_IDLE,
		RD_ANSWER
	} rd_state_t;

endpackage

// [logic/motor_status_readback_regs.sv]
// Read-only status register bank: position, supply, speed, analog, ident
`timescale 1ns/10ps

module motor_status_readback_regs #(
	parameter logic [7:0] DIE_ID = motor_status_pkg::DIE_ID_DEFAULT,
	parameter logic [7:0] REV_ID = motor_status_pkg::REV_ID_DEFAULT
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] initial_rotor_angle,
	input wire logic [7:0] detect_advance_angle,
	input wire logic [7:0] supply_level_code,
	input wire logic [7:0] raw_speed_command,
	input wire logic [7:0] buffered_speed_command,
	input wire logic [9:0] analog_speed_adc_code,
	input wire logic rd_en,
	input wire logic [motor_status_pkg::ADDR_W-1:0] rd_addr,
	input wire logic wr_en,
	input wire logic [motor_status_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [motor_status_pkg::WORD_W-1:0] wr_data,
	output logic [motor_status_pkg::WORD_W-1:0] rd_data_r,
	output logic rd_valid_r,
	output logic rd_hit_r,
	output logic wr_dropped_r
);
	import motor_status_pkg::*;

	// Angle sum, one cycle behind its sources like every other field
	logic [7:0] angle_sum_r;
	// Sampled measurement and command sources
	logic [7:0] supply_r;
	logic [7:0] raw_cmd_r;
	logic [7:0] buf_cmd_r;
	logic [9:0] adc_r;
	// Assembled register words
	logic [15:0] word_pos;
	logic [15:0] word_speed;
	logic [15:0] word_analog;
	logic [15:0] word_ident;
	// Decoded read word and hit flag
	logic [15:0] rd_word;
	logic rd_hit;
	// Read port state
	rd_state_t rd_state_r;
	rd_state_t rd_state_nxt;
	// Unused write payload; kept only to show it has no effect
	logic wr_data_seen;

	// Detected angle plus advance, registered in a leaf adder
	rotor_angle_adder #(
		.W(BYTE_W)
	) u_angle (
		.clk(clk),
		.arst_n(arst_n),
		.estimate(initial_rotor_angle),
		.advance(detect_advance_angle),
		.sum_r(angle_sum_r)
	);

	// Sample every source each cycle; no capture command is needed
	// Sampling once here keeps a read word from mixing two source cycles
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			supply_r <= RST_BYTE;
			raw_cmd_r <= RST_BYTE;
			buf_cmd_r <= RST_BYTE;
			adc_r <= RST_ADC;
		end else begin
			supply_r <= supply_level_code;
			raw_cmd_r <= raw_speed_command;
			buf_cmd_r <= buffered_speed_command;
			adc_r <= analog_speed_adc_code;
		end
	end

	// Word assembly from the sampled fields
	always_comb begin
		word_pos = {angle_sum_r, supply_r};
		word_speed = {raw_cmd_r, buf_cmd_r};
		word_analog = {RSVD_ZERO, adc_r};
		word_ident = {DIE_ID, REV_ID};
	end

	// Address decode; unmapped offsets read as zero
	always_comb begin
		rd_hit = 1'b1;
		case (rd_addr)
			OFS_POSITION_SUPPLY: begin
				rd_word = word_pos;
			end
			OFS_SPEED_READBACK: begin
				rd_word = word_speed;
			end
			OFS_ANALOG_LEVEL: begin
				rd_word = word_analog;
			end
			OFS_IDENT: begin
				rd_word = word_ident;
			end
			default: begin
				rd_word = UNMAPPED_WORD;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read port sequencing: answer one cycle after the request
	always_comb begin
		case (rd_state_r)
			RD_IDLE: begin
				rd_state_nxt = rd_en ? RD_ANSWER : RD_IDLE;
			end
			RD_ANSWER: begin
				// Back-to-back reads keep the port in the answer state
				rd_state_nxt = rd_en ? RD_ANSWER : RD_IDLE;
			end
			default: begin
				rd_state_nxt = RD_IDLE;
			end
		endcase
	end

	// State register of the read port
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_state_r <= RD_IDLE;
		end else begin
			rd_state_r <= rd_state_nxt;
		end
	end

	// Read answer registers; data holds until the next read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_r <= RST_WORD;
			rd_valid_r <= 1'b0;
			rd_hit_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_en;
			if (rd_en) begin
				rd_data_r <= rd_word;
				rd_hit_r <= rd_hit;
			end
		end
	end

	// Writes land nowhere; a pulse only reports that one was dropped
	always_comb begin
		wr_data_seen = |wr_data;
	end

	// Dropped write pulse, one cycle after any write request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_dropped_r <= 1'b0;
		end else begin
			wr_dropped_r <= wr_en;
		end
	end

	// Checks on the read path
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// Read of a given offset, answered on the next edge
	sequence s_read_pos;
		rd_en && rd_addr == OFS_POSITION_SUPPLY;
	endsequence
	sequence s_read_speed;
		rd_en && rd_addr == OFS_SPEED_READBACK;
	endsequence
	sequence s_read_analog;
		rd_en && rd_addr == OFS_ANALOG_LEVEL;
	endsequence

	a_angle_sum_read: assert property (
		s_read_pos ##1 rd_valid_r |-> rd_data_r[15:8] ==
		8'($past(initial_rotor_angle, 2) + $past(detect_advance_angle, 2)))
		else $error("position byte is not angle plus advance");

	a_supply_byte_read: assert property (
		s_read_pos |=> rd_data_r[7:0] == $past(supply_level_code, 2))
		else $error("supply byte does not track the source");

	a_raw_cmd_read: assert property (
		s_read_speed |=> rd_data_r[15:8] == $past(raw_speed_command, 2))
		else $error("raw speed byte does not track the source");

	a_buf_cmd_read: assert property (
		s_read_speed |=> rd_data_r[7:0] == $past(buffered_speed_command, 2))
		else $error("buffered speed byte does not track the source");

	a_adc_code_read: assert property (
		s_read_analog |=> rd_data_r[9:0] == $past(analog_speed_adc_code, 2))
		else $error("analog code does not track the converter");

	a_analog_rsvd_zero: assert property (
		s_read_analog |=> rd_data_r[15:10] == 6'h00 && rd_hit_r)
		else $error("analog reserved bits not zero");

	a_ident_fixed: assert property (
		rd_en && rd_addr == OFS_IDENT |=> rd_data_r == {DIE_ID, REV_ID})
		else $error("identification word is not the fixed value");

	// Revision byte checked on its own so a swapped byte order shows up
	a_revision_byte: assert property (
		rd_en && rd_addr == OFS_IDENT |=> rd_data_r[7:0] == REV_ID && rd_hit_r)
		else $error("revision byte is not the fixed value");

	// Every read is answered on the next edge, with no capture step
	a_read_answered: assert property (
		rd_en |=> rd_valid_r && rd_state_r == RD_ANSWER)
		else $error("read request was not answered");

	a_data_holds_idle: assert property (
		!rd_en |=> $stable(rd_data_r) && !rd_valid_r)
		else $error("read data moved without a read");

	a_write_no_effect: assert property (
		wr_en && !rd_en |=> wr_dropped_r ##0 $stable(rd_data_r))
		else $error("write changed the read answer");

	// Offsets past the bank answer zero and report a miss
	a_unmapped_zero: assert property (
		rd_en && rd_addr > OFS_IDENT |=> rd_data_r == 16'h0000 && !rd_hit_r)
		else $error("unmapped offset did not read zero");

endmodule

// [logic/rotor_angle_adder.sv]
// Registered modulo-256 sum of estimated rotor angle and advance angle
`timescale 1ns/10ps
module rotor_angle_adder #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] estimate,
	input wire logic [W-1:0] advance,
	output logic [W-1:0] sum_r
);
	// Sum before the register; the carry out is dropped on purpose
	logic [W:0] sum_wide;

	// Full-width add so the truncation below is explicit
	always_comb begin
		sum_wide = {1'b0, estimate} + {1'b0, advance};
	end

	// Angle wraps around a full turn, so only the low bits are kept
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sum_r <= '0;
		end else begin
			sum_r <= sum_wide[W-1:0];
		end
	end
endmodule

// [tb/status_host_model.sv]
// Host model that issues register reads and captures each answer
`timescale 1ns/10ps
module status_host_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic go,
	input wire logic [7:0] addr,
	input wire logic rd_valid_r,
	input wire logic [15:0] rd_data_r,
	output logic rd_en,
	output logic [7:0] rd_addr,
	output logic [15:0] word,
	output logic done
);
	// One-cycle read strobe; the host only reads, never writes reserved bits
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_en <= 1'b0;
			rd_addr <= 8'h00;
		end else begin
			rd_en <= go;
			// Idle address toggles so a stale offset is never reused by luck
			rd_addr <= go ? addr : ~rd_addr;
		end
	end

	// Capture the answer in the one cycle that it stands
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			word <= 16'h0000;
			done <= 1'b0;
		end else begin
			word <= rd_valid_r ? rd_data_r : word;
			done <= rd_valid_r;
		end
	end
endmodule

// [tb/test_motor_status_readback_regs.sv]
// Testbench for the read-only status register bank
`timescale 1ns/10ps
module test_motor_status_readback_regs;
	import motor_status_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] ang = 8'h00, adv = 8'h00, sup = 8'h00;
	logic [7:0] raw = 8'h00, bufc = 8'h00;
	logic [9:0] adc = 10'h000;
	logic go = 1'b0, wr_en = 1'b0;
	logic [7:0] addr = 8'h00, wr_addr = 8'h00;
	logic [15:0] wr_data = 16'h0000;
	wire logic rd_en, rd_valid_r, rd_hit_r, wr_dropped_r, done;
	wire logic [7:0] rd_addr;
	wire logic [15:0] rd_data_r, word;
	int n_mismatch = 0;
	int n_tests = 0;

	// Free-running clock, 8 ns period
	always #4 clk = ~clk;

	motor_status_readback_regs motor_status_readback_regs_inst (
		.clk(clk), .arst_n(arst_n), .initial_rotor_angle(ang),
		.detect_advance_angle(adv), .supply_level_code(sup),
		.raw_speed_command(raw), .buffered_speed_command(bufc),
		.analog_speed_adc_code(adc), .rd_en(rd_en), .rd_addr(rd_addr),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
		.rd_hit_r(rd_hit_r), .wr_dropped_r(wr_dropped_r));

	status_host_model status_host_model_inst (
		.clk(clk), .arst_n(arst_n), .go(go), .addr(addr),
		.rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .rd_en(rd_en),
		.rd_addr(rd_addr), .word(word), .done(done));

	// Count and report one comparison
	task chk(string what, logic [15:0] exp, logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One read through the host model, waiting a bounded time for it
	task rd(logic [7:0] a, logic [15:0] exp, logic hit);
		int i;
		@(posedge clk);
		go <= 1'b1;
		addr <= a;
		@(posedge clk);
		go <= 1'b0;
		for (i = 0; i < 8 && done !== 1'b1; i++)
			@(negedge clk);
		chk("read done", 16'h0001, {15'h0000, done});
		chk("read word", exp, word);
		chk("read hit", {15'h0000, hit}, {15'h0000, rd_hit_r});
		// The answer pulse stands for one cycle only
		@(negedge clk);
		chk("read pulse end", 16'h0000, {15'h0000, done});
	endtask

	// Ignored write, then its marker pulse
	task wr(logic [7:0] a, logic [15:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		@(negedge clk);
		chk("write marker", 16'h0001, {15'h0000, wr_dropped_r});
		@(negedge clk);
		chk("write marker end", 16'h0000, {15'h0000, wr_dropped_r});
	endtask

	task t_reset;
		rd(OFS_SPEED_READBACK, 16'h0000, 1'b1);
		rd(OFS_ANALOG_LEVEL, 16'h0000, 1'b1);
		$display("t_reset done");
	endtask

	// Extreme codes; the angle sum wraps past 255
	task t_fields;
		@(posedge clk);
		ang <= 8'hf0;
		adv <= 8'h20;
		sup <= 8'h67;
		raw <= FULL_SPEED_CODE;
		bufc <= 8'h80;
		adc <= 10'h3ff;
		rd(OFS_POSITION_SUPPLY, 16'h1067, 1'b1);
		rd(OFS_SPEED_READBACK, 16'hff80, 1'b1);
		rd(OFS_ANALOG_LEVEL, 16'h03ff, 1'b1);
		rd(OFS_IDENT, {DIE_ID_DEFAULT, REV_ID_DEFAULT}, 1'b1);
		rd(8'h09, 16'h0000, 1'b0);
		$display("t_fields done");
	endtask

	// Writes must leave the speed, analog and ident readbacks untouched
	task t_write;
		wr(OFS_SPEED_READBACK, 16'h0000);
		wr(OFS_ANALOG_LEVEL, 16'h0155);
		wr(OFS_IDENT, 16'h0000);
		rd(OFS_SPEED_READBACK, 16'hff80, 1'b1);
		rd(OFS_ANALOG_LEVEL, 16'h03ff, 1'b1);
		rd(OFS_IDENT, {DIE_ID_DEFAULT, REV_ID_DEFAULT}, 1'b1);
		$display("t_write done");
	endtask

	// New source values show with no capture command
	task t_track;
		@(posedge clk);
		ang <= 8'h00;
		adv <= 8'h00;
		sup <= 8'hff;
		raw <= 8'h01;
		bufc <= 8'hfe;
		adc <= 10'h200;
		rd(OFS_POSITION_SUPPLY, 16'h00ff, 1'b1);
		rd(OFS_SPEED_READBACK, 16'h01fe, 1'b1);
		rd(OFS_ANALOG_LEVEL, 16'h0200, 1'b1);
		$display("t_track done");
	endtask

	// Reset in mid-run clears the answer, then reads track sources again
	task t_midreset;
		@(posedge clk);
		arst_n <= 1'b0;
		@(negedge clk);
		chk("reset data", RST_WORD, rd_data_r);
		chk("reset hit", 16'h0000, {15'h0000, rd_hit_r});
		@(posedge clk);
		arst_n <= 1'b1;
		rd(OFS_SPEED_READBACK, 16'h01fe, 1'b1);
		$display("t_midreset done");
	endtask

	// Counts, verdict and end of run
	task summarize;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence after a 16-cycle reset
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_fields();
		t_write();
		t_track();
		t_midreset();
		summarize();
	end

	// Watchdog, well beyond the hundred or so cycles the tests need
	initial begin
		#20000;
		n_mismatch++;
		summarize();
	end
endmodule
